// [rtl/acl_filter.sv]
// per-port ingress access control list engine with AHB-Lite register slave
// Functional notes
// - each port holds an ordered 16-entry table applied to its ingress frames
// - tests MAC/EtherType, masked IPv4 addresses, protocol, TCP/UDP ports, masked TCP flags
// - a counting entry raises an event instead of any forwarding action
// - watchdog mode signals when no matching frame arrives within the interval
// - event mode signals once the programmed number of matching frames arrived
// - counting uses the 11-bit value of the action at the same index
// - outside counting, match slots and action slots are independent
// - a processing entry ANDs all selected match results before invoking its action
// - several processing entries on one action give an OR
// - all matches evaluated; lowest action pointer among true entries wins, one action only
// - action pointer is 4 bits selecting action slots 0 to 15
// - 16-bit selection mask, one bit per match slot, 1 includes it
// - layer and option selectors choose the test; layer 00 disables the rule
// - layer 01: option 00 count, 01 address, 10 EtherType, 11 both
// - layer 10: 01 masked single IPv4 address, 10 both addresses unmasked, others reserved
// - layer 11: 00 protocol, 01 TCP port, 10 UDP port, 11 TCP sequence
// - a hit decision may override the other forwarding functions
// - time unit bit: 0 microseconds, 1 milliseconds
// - algorithm 0 loads and counts down per unit; 1 counts frames up, then resets
// - equality polarity 0: mismatch is true; 1: match is true
// - direction bit 0 selects destination field, 1 selects source field
`timescale 1ns/1ns
`default_nettype none
module acl_filter
	import acl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire frame_s frame,
	output decision_s decision,
	output logic [N_ENT-1:0] count_event
);
	// decoded window: control block flag, entry number, byte offset
	typedef struct packed {
		logic blk;
		logic [3:0] ent;
		logic [4:0] ofs;
	} win_addr_s;
	// upper match word as laid out for layer 2 and for the TCP flag test
	typedef struct packed {
		logic [15:0] mac_hi;
		logic [15:0] ethertype;
	} l2_word_s;
	typedef struct packed {
		logic [15:0] spare;
		logic [7:0] flag_mask;
		logic [7:0] flag_value;
	} flag_word_s;
	typedef enum logic [7:0] {
		REG_NONE = 8'h01,
		REG_MCTRL = 8'h02,
		REG_MDATA0 = 8'h04,
		REG_MDATA1 = 8'h08,
		REG_ACTION = 8'h10,
		REG_PROC = 8'h20,
		REG_COUNT = 8'h40,
		REG_CTRL = 8'h80
	} reg_e;
	localparam int ALIGN_W = 2;
	localparam int CTRL_EN_BIT = 0;

	typedef struct packed {
		entry_s [N_ENT-1:0] ent;
		logic [N_ENT-1:0][CNT_W-1:0] cnt;
		logic [6:0] us_div;
		logic [9:0] ms_div;
		logic enable;
		logic wr_pend;
		logic rd_wait;
		logic mapped;
		win_addr_s addr;
		logic [31:0] rdata;
		decision_s dec;
		logic [N_ENT-1:0] ev;
	} state_s;

	state_s s;
	state_s next_s;

	function automatic logic is_count(entry_s e);
		return e.m.c.match_layer_select == LAYER_L2 && e.m.c.match_option_select == L2_COUNT;
	endfunction

	function automatic logic mac_type_eq(match_s m, frame_s f, logic want_mac, logic want_type);
		logic [47:0] mac;
		l2_word_s hi;
		mac = m.c.dir_source ? f.src_mac : f.dst_mac;
		hi = m.data1;
		return (!want_mac || mac == {hi.mac_hi, m.data0})
			&& (!want_type || f.ethertype == hi.ethertype);
	endfunction

	// a counting entry follows frames on address and EtherType, whatever the polarity bit
	function automatic logic count_hit(match_s m, frame_s f);
		return f.valid && mac_type_eq(m, f, 1'b1, 1'b1);
	endfunction

	// lowest set bit wins: slot 0 has the highest priority
	function automatic logic [4:0] pick_lowest(logic [N_ENT-1:0] req);
		logic [4:0] r;
		r = '0;
		for (int i = N_ENT - 1; i >= 0; i--)
		begin
			if (req[i])
				r = {1'b1, 4'(i)};
		end
		return r;
	endfunction

	function automatic logic match_eval(match_s m, frame_s f);
		logic eqv;
		logic ok;
		logic [31:0] ip;
		logic [15:0] port;
		logic [7:0] fm;
		flag_word_s fw;
		ip = m.c.dir_source ? f.src_ip : f.dst_ip;
		port = m.c.dir_source ? f.src_port : f.dst_port;
		fw = m.data1;
		fm = ~fw.flag_mask;
		eqv = 1'b0;
		ok = 1'b1;
		case (m.c.match_layer_select)
			LAYER_L2:
			begin
				case (m.c.match_option_select)
					L2_MAC: eqv = mac_type_eq(m, f, 1'b1, 1'b0);
					L2_TYPE: eqv = mac_type_eq(m, f, 1'b0, 1'b1);
					L2_BOTH: eqv = mac_type_eq(m, f, 1'b1, 1'b1);
					default: ok = 1'b0; // counting gives no forwarding result
				endcase
			end
			LAYER_L3:
			begin
				case (m.c.match_option_select)
					L3_MASKED: eqv = f.ipv4 && ((ip ^ m.data0) & ~m.data1) == 32'h0;
					L3_PAIR: eqv = f.ipv4 && f.src_ip == m.data0 && f.dst_ip == m.data1;
					default: ok = 1'b0;
				endcase
			end
			LAYER_L4:
			begin
				case (m.c.match_option_select)
					L4_PROTO: eqv = f.ipv4 && f.proto == 8'(m.data0);
					L4_TCP: eqv = f.tcp && port == 16'(m.data0);
					L4_UDP: eqv = f.udp && port == 16'(m.data0);
					default: eqv = f.tcp && f.tcp_seq == m.data0
						&& (f.tcp_flags & fm) == (fw.flag_value & fm);
				endcase
			end
			default: ok = 1'b0;
		endcase
		return ok && (m.c.equality_polarity ? eqv : !eqv);
	endfunction

	// one decoder shared by the read mux and the write commit
	function automatic reg_e reg_decode(logic mapped, win_addr_s a);
		reg_e k;
		k = REG_NONE;
		if (!mapped)
			k = REG_NONE;
		else if (a == ADDR_CTRL)
			k = REG_CTRL;
		else if (a.blk)
			k = REG_NONE;
		else if (a.ofs == OFS_MATCH_CTRL)
			k = REG_MCTRL;
		else if (a.ofs == OFS_MATCH_DATA0)
			k = REG_MDATA0;
		else if (a.ofs == OFS_MATCH_DATA1)
			k = REG_MDATA1;
		else if (a.ofs == OFS_ACTION)
			k = REG_ACTION;
		else if (a.ofs == OFS_PROC)
			k = REG_PROC;
		else if (a.ofs == OFS_COUNT)
			k = REG_COUNT;
		return k;
	endfunction

	// holes and reserved bits read as zero
	function automatic logic [31:0] rd_word(state_s st);
		logic [31:0] w;
		w = 32'h0;
		case (reg_decode(st.mapped, st.addr))
			REG_CTRL: w = 32'(st.enable);
			REG_MCTRL: w = 32'(st.ent[st.addr.ent].m.c);
			REG_MDATA0: w = st.ent[st.addr.ent].m.data0;
			REG_MDATA1: w = st.ent[st.addr.ent].m.data1;
			REG_ACTION: w = 32'(st.ent[st.addr.ent].a);
			REG_PROC: w = 32'(st.ent[st.addr.ent].p);
			REG_COUNT: w = 32'(st.cnt[st.addr.ent]);
			default: w = 32'h0;
		endcase
		return w;
	endfunction

	logic [N_ENT-1:0] mres;
	logic [N_ENT-1:0] ahit;
	logic found;
	logic [3:0] win;
	logic us_tick;
	logic ms_tick;

	always_comb
	begin
		next_s = s;
		mres = '0;
		ahit = '0;
		found = 1'b0;
		win = 4'h0;
		next_s.ev = '0;
		// every match slot is evaluated for each frame
		for (int i = 0; i < N_ENT; i++)
			mres[i] = match_eval(s.ent[i].m, frame);
		for (int p = 0; p < N_ENT; p++)
		begin
			// empty mask never fires; an action slot that holds a count value is never taken
			if (s.enable && frame.valid && s.ent[p].p.match_select_mask != 16'h0
				&& (s.ent[p].p.match_select_mask & ~mres) == 16'h0
				&& !is_count(s.ent[s.ent[p].p.action_pointer]))
				ahit[s.ent[p].p.action_pointer] = 1'b1;
		end
		{found, win} = pick_lowest(ahit);
		next_s.dec.valid = frame.valid;
		next_s.dec.hit = found;
		next_s.dec.idx = win;
		next_s.dec.act = found ? s.ent[win].a : '0;

		us_tick = s.us_div == US_LAST;
		ms_tick = us_tick && s.ms_div == MS_LAST;
		next_s.us_div = us_tick ? 7'h0 : s.us_div + 7'h1;
		if (us_tick)
			next_s.ms_div = ms_tick ? 10'h0 : s.ms_div + 10'h1;
		for (int i = 0; i < N_ENT; i++)
		begin
			if (!is_count(s.ent[i]) || !s.enable)
				next_s.cnt[i] = '0;
			else if (!s.ent[i].a.count_algorithm_select)
			begin
				// a reload wins over a tick; the free-running prescaler makes the first unit short
				if (count_hit(s.ent[i].m, frame))
					next_s.cnt[i] = s.ent[i].a.value;
				else if ((s.ent[i].a.count_time_unit ? ms_tick : us_tick) && s.cnt[i] != '0)
				begin
					next_s.cnt[i] = s.cnt[i] - 11'h1;
					next_s.ev[i] = s.cnt[i] == 11'h1;
				end
			end
			else if (count_hit(s.ent[i].m, frame))
			begin
				if ({1'b0, s.cnt[i]} + 12'h1 >= {1'b0, s.ent[i].a.value})
				begin
					next_s.ev[i] = 1'b1;
					next_s.cnt[i] = '0;
				end
				else
					next_s.cnt[i] = s.cnt[i] + 11'h1;
			end
		end

		// write data phase: commit at the stored address; bus writes beat counter updates
		if (s.wr_pend)
		begin
			case (reg_decode(s.mapped, s.addr))
				REG_CTRL: next_s.enable = hwdata[CTRL_EN_BIT];
				REG_MCTRL: next_s.ent[s.addr.ent].m.c = mctrl_s'(hwdata[$bits(mctrl_s)-1:0]);
				REG_MDATA0: next_s.ent[s.addr.ent].m.data0 = hwdata;
				REG_MDATA1: next_s.ent[s.addr.ent].m.data1 = hwdata;
				REG_ACTION:
				begin
					next_s.ent[s.addr.ent].a = action_s'(hwdata[$bits(action_s)-1:0]);
					next_s.cnt[s.addr.ent] = '0;
				end
				REG_PROC: next_s.ent[s.addr.ent].p = proc_s'(hwdata[$bits(proc_s)-1:0]);
				default: next_s.enable = s.enable; // count word and holes ignore writes
			endcase
		end
		// reads take one wait state so a write just before is already visible
		if (s.rd_wait)
		begin
			next_s.rdata = rd_word(s);
			next_s.rd_wait = 1'b0;
		end
		next_s.wr_pend = 1'b0;
		if (hsel && htrans[1] && hready)
		begin
			next_s.addr = win_addr_s'(haddr[$bits(win_addr_s)-1:0]);
			next_s.mapped = haddr[31:$bits(win_addr_s)] == '0 && haddr[ALIGN_W-1:0] == '0;
			next_s.wr_pend = hwrite;
			next_s.rd_wait = !hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s <= '0;
			s.enable <= CTRL_RESET;
		end
		else
			s <= next_s;
	end

	assign hreadyout = !s.rd_wait;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign decision = s.dec;
	assign count_event = s.ev;
endmodule // acl_filter
`default_nettype wire

// [rtl/acl_pkg.sv]
// shared constants, register map and carrier types of the ingress filter engine
package acl_pkg;
	localparam int N_ENT = 16;
	localparam int CNT_W = 11;
	localparam logic [1:0] LAYER_OFF = 2'h0;
	localparam logic [1:0] LAYER_L2 = 2'h1;
	localparam logic [1:0] LAYER_L3 = 2'h2;
	localparam logic [1:0] LAYER_L4 = 2'h3;
	localparam logic [1:0] L2_COUNT = 2'h0;
	localparam logic [1:0] L2_MAC = 2'h1;
	localparam logic [1:0] L2_TYPE = 2'h2;
	localparam logic [1:0] L2_BOTH = 2'h3;
	localparam logic [1:0] L3_MASKED = 2'h1;
	localparam logic [1:0] L3_PAIR = 2'h2;
	localparam logic [1:0] L4_PROTO = 2'h0;
	localparam logic [1:0] L4_TCP = 2'h1;
	localparam logic [1:0] L4_UDP = 2'h2;
	localparam logic [1:0] L4_SEQ = 2'h3;
	// byte offsets inside one entry block, entry i at i*0x20
	localparam logic [4:0] OFS_MATCH_CTRL = 5'h00;
	localparam logic [4:0] OFS_MATCH_DATA0 = 5'h04;
	localparam logic [4:0] OFS_MATCH_DATA1 = 5'h08;
	localparam logic [4:0] OFS_ACTION = 5'h0C;
	localparam logic [4:0] OFS_PROC = 5'h10;
	localparam logic [4:0] OFS_COUNT = 5'h14;
	localparam logic [9:0] ADDR_CTRL = 10'h200;
	localparam logic CTRL_RESET = 1'b0;
	localparam int CLK_NS = 10;
	localparam int US_NS = 1000;
	localparam int MS_US = 1000;
	localparam int US_CYC = US_NS / CLK_NS;
	localparam logic [6:0] US_LAST = 7'(US_CYC - 1);
	localparam logic [9:0] MS_LAST = 10'(MS_US - 1);
	typedef struct packed {
		logic equality_polarity;
		logic dir_source;
		logic [1:0] match_option_select;
		logic [1:0] match_layer_select;
	} mctrl_s;
	typedef struct packed {
		mctrl_s c;
		logic [31:0] data0;
		logic [31:0] data1;
	} match_s;
	typedef struct packed {
		logic count_algorithm_select;
		logic count_time_unit;
		logic [CNT_W-1:0] value;
	} action_s;
	typedef struct packed {
		logic [15:0] match_select_mask;
		logic [3:0] action_pointer;
	} proc_s;
	typedef struct packed {
		match_s m;
		action_s a;
		proc_s p;
	} entry_s;
	typedef struct packed {
		logic valid;
		logic [47:0] dst_mac;
		logic [47:0] src_mac;
		logic [15:0] ethertype;
		logic ipv4;
		logic [31:0] src_ip;
		logic [31:0] dst_ip;
		logic [7:0] proto;
		logic tcp;
		logic udp;
		logic [15:0] src_port;
		logic [15:0] dst_port;
		logic [31:0] tcp_seq;
		logic [7:0] tcp_flags;
	} frame_s;
	typedef struct packed {
		logic valid;
		logic hit;
		logic [3:0] idx;
		action_s act;
	} decision_s;
endpackage

// [test/acl_filter_assertions.sv]
// port checks for the filter engine
`timescale 1ns/1ns
`default_nettype none
module acl_filter_assertions
	import acl_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire frame_s frame,
	input wire decision_s decision
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence take_rd;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_dec_follow: assert property (frame.valid |=> decision.valid)
		else $error("no decision");
	chk_dec_quiet: assert property (!frame.valid |=> !decision.valid)
		else $error("stray decision");
	chk_hit_valid: assert property (decision.hit |-> decision.valid)
		else $error("stray hit");
	chk_miss_act: assert property (decision.valid && !decision.hit |-> decision.act == '0)
		else $error("action on miss");
	chk_rd_wait: assert property (take_rd |=> one_wait)
		else $error("bad read wait");
	chk_wr_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_ready_back: assert property (!hreadyout |=> hreadyout)
		else $error("long stall");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
endmodule // acl_filter_assertions
bind acl_filter acl_filter_assertions i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .frame(frame), .decision(decision));
`default_nettype wire

// [test/acl_filter_tb_top.sv]
// self-checking bench for the ingress filter engine
`timescale 1ns/1ns
`default_nettype none
module acl_filter_tb_top
	import acl_pkg::*;
;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, send = 1'b0, hreadyout, hresp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [15:0] count_event;
	frame_s pkt, frame;
	decision_s decision;
	int err_count = 0, comparisons = 0, n;
	typedef struct packed {logic [5:0] c; logic [31:0] d0, d1; logic hit;} row_s;
	// entry 0 control, match words, expected hit
	row_s rows [13] = '{
		'{6'h2C, 32'h1, 32'hAAAA0800, 1'b0}, '{6'h25, 32'h1, 32'hAAAA0000, 1'b1},
		'{6'h35, 32'h1, 32'hAAAA0000, 1'b0}, '{6'h15, 32'h1, 32'hAAAA0000, 1'b1},
		'{6'h29, 32'h0, 32'h800, 1'b1}, '{6'h2D, 32'h1, 32'hAAAA0800, 1'b1},
		'{6'h26, 32'hA0000FF, 32'hFF, 1'b1}, '{6'h2A, 32'hA000001, 32'hA000002, 1'b1},
		'{6'h22, 32'hA000001, 32'hA000002, 1'b0}, '{6'h23, 32'h6, 32'h0, 1'b1},
		'{6'h27, 32'h50, 32'h0, 1'b1}, '{6'h2B, 32'h50, 32'h0, 1'b0},
		'{6'h2F, 32'h10000000, 32'h12, 1'b1}};
	always #5 hclk = ~hclk;
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hsize <= 3'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [31:0] a, e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic fire();
		send <= 1'b1;
		@(posedge hclk);
		send <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	task automatic end_sim();
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	acl_filter i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.frame(frame), .decision(decision), .count_event(count_event));
	frame_source i_src (.hclk(hclk), .send(send), .pkt(pkt), .frame(frame));
	initial
	begin
		#500000;
		err_count++;
		end_sim();
	end
	initial
	begin
		pkt = '{1'b1, 48'hAAAA00000001, 48'hBBBB00000002, 16'h800, 1'b1, 32'hA000001, 32'hA000002,
			8'h6, 1'b1, 1'b0, 16'h1234, 16'h50, 32'h10000000, 8'h12};
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(32'h200, 32'h0);
		bus(1'b1, 32'h00C, 32'h5A5);
		bus(1'b1, 32'h010, 32'h10);
		bus(1'b1, 32'h000, 32'h29);
		bus(1'b1, 32'h008, 32'h800);
		fire();
		chk(32'({decision.valid, decision.hit}), 32'h2);
		bus(1'b1, 32'h200, 32'h1);
		foreach (rows[i])
		begin
			bus(1'b1, 32'h000, 32'(rows[i].c));
			bus(1'b1, 32'h004, rows[i].d0);
			bus(1'b1, 32'h008, rows[i].d1);
			fire();
			chk(32'({decision.hit, decision.idx, decision.act}), rows[i].hit ? 32'h205A5 : 32'h0);
		end
		bus(1'b1, 32'h000, 32'h0);
		bus(1'b1, 32'h020, 32'h29);
		bus(1'b1, 32'h028, 32'h800);
		bus(1'b1, 32'h040, 32'h2B);
		bus(1'b1, 32'h030, 32'h63);
		bus(1'b1, 32'h050, 32'h25);
		fire();
		chk(32'({decision.hit, decision.idx}), 32'h15);
		bus(1'b1, 32'h070, 32'h44);
		bus(1'b1, 32'h090, 32'h24);
		fire();
		chk(32'({decision.hit, decision.idx}), 32'h14);
		for (n = 0; n < 6; n++)
			bus(1'b1, 32'(192 + n % 3 * 4 + n / 3 * 32), n % 3 == 2 ? 32'hAAAA0800 : 32'h1);
		bus(1'b1, 32'h0CC, 32'h1003);
		bus(1'b1, 32'h0EC, 32'h2);
		for (n = 1; n < 4; n++)
		begin
			fire();
			chk(32'(count_event), n == 3 ? 32'h40 : 32'h0);
			if (n == 1)
				rdchk(32'h0D4, 32'h1);
		end
		n = 0;
		while (count_event[7] !== 1'b1 && n < 400)
		begin
			@(posedge hclk);
			n++;
		end
		chk(32'(n > 100 && n < 201), 32'h1);
		bus(1'b1, 32'h1E0, 32'hFFFFFFFF);
		rdchk(32'h1E0, 32'h3F);
		rdchk(32'h400, 32'h0);
		// mid-run reset: outputs idle at once, table and enable cleared
		hresetn <= 1'b0;
		@(posedge hclk);
		chk(32'(decision), 32'h0);
		chk(32'({hreadyout, hresp, count_event}), 32'h20000);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(32'h200, 32'h0);
		rdchk(32'h1E0, 32'h0);
		end_sim();
	end
endmodule // acl_filter_tb_top
`default_nettype wire

// [test/frame_source.sv]
// parser stand-in: one frame per request
`timescale 1ns/1ns
`default_nettype none
module frame_source
	import acl_pkg::*;
(
	input wire logic hclk,
	input wire logic send,
	input wire frame_s pkt,
	output var frame_s frame
);
	initial frame = '0;
	// idle header bus toggles so stale fields never pass for live ones
	always @(posedge hclk)
	begin
		frame <= send ? pkt : ~frame;
		frame.valid <= send;
	end
endmodule // frame_source
`default_nettype wire
